// ==== core/ecp_pkg.sv ====
// Package of constants and carrier types for the ECP parallel port core.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
// Contract
// - Forward bytes are paced by host strobe against the peripheral flow reply.
// - Reverse bytes are paced by the peripheral clock against host reply.
// - Flow reply is forward flow control; in reverse it tags command or data.
// - Host reply requests reverse bytes; in forward it tags command or data.
// - Turnaround ask low with active high lets the peripheral drive the bus.
// - Active indicator stays high throughout ECP mode.
// - Data latch clears on reset, drives bus uninverted, reads port contents.
// - Address FIFO writes are tagged address bytes sent forward in ECP mode.
// - Status bits 2 to 0 always read as ones.
// - Status bit 7 is inverted flow reply; bits 6..3 read inputs directly.
// - Control bits 7,6 read high; bits 5..0 clear on reset.
// - Control bit 5 selects direction; forced low in standard mode.
// - Control bit 4 enables an interrupt on peripheral clock rising edges.
// - Control bits 3..0 drive active, turnaround, host reply, strobe outputs.
// - Parallel FIFO mode sends FIFO bytes forward with standard handshake.
// - ECP mode sends FIFO bytes forward, or fills the FIFO in reverse.
// - Test mode FIFO: free access, no handshake, refuse full, empty repeats.
// - Configuration A reads a fixed value in configuration mode.
// - Configuration B is read-only and reads zero in all listed fields.
// - A 16-byte FIFO serves both directions.
// - Extended control top three bits select the operating mode.
package ecp_pkg;
  // -------------------------------------------------------------------------
  // Offsets and values
  // -------------------------------------------------------------------------
  localparam logic [1:0] OFF_DATA = 2'h0;
  localparam logic [1:0] OFF_STATUS = 2'h1;
  localparam logic [1:0] OFF_CONTROL = 2'h2;
  localparam logic [1:0] OFF_FIFO = 2'h0;
  localparam logic [1:0] OFF_CFG_B = 2'h1;
  localparam logic [1:0] OFF_EXT_CTRL = 2'h2;
  localparam logic [7:0] CFG_A_VALUE = 8'h10;
  localparam logic [7:0] CFG_B_VALUE = 8'h00;
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] EXT_MODE_RESET = 3'h0;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int PULSE_NS = 500;
  localparam int CLK_NS = 10;
  localparam logic [7:0] PULSE_CYC = 8'((PULSE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    MODE_STD = 3'h0,
    MODE_PS2 = 3'h1,
    MODE_PFIFO = 3'h2,
    MODE_ECP = 3'h3,
    MODE_TEST = 3'h6,
    MODE_CFG = 3'h7
  } port_mode_t;

  typedef enum logic [4:0] {
    LK_IDLE = 5'h01,
    LK_SETUP = 5'h02,
    LK_STROBE = 5'h04,
    LK_WAIT_REL = 5'h08,
    LK_REV = 5'h10
  } link_state_t;

  // FIFO word: tag bit (1 = address or command) over the byte.
  typedef struct packed {
    logic tag;
    logic [7:0] byte_v;
  } fifo_word_t;

  typedef struct packed {
    logic flow_reply;
    logic rev_clk;
    logic paper;
    logic online;
    logic fault_n;
  } pins_in_t;
endpackage : ecp_pkg

// ==== core/ecp_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ecp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_b_i, // Synchronous reset, active low.
  input wire logic flush_i, // Empties the FIFO.
  input wire logic [WIDTH-1:0] in_data_i, // Fill data.
  input wire logic in_valid_i, // Fill request.
  output logic in_ready_o, // Not full.
  output logic [WIDTH-1:0] out_data_o, // Head word.
  output logic out_valid_o, // Not empty.
  input wire logic out_ready_i, // Drain request.
  output logic full_o, // Full flag.
  output logic empty_o // Empty flag.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign full_o = (cnt_r == (AW+1)'(DEPTH));
  assign empty_o = (cnt_r == '0);
  assign in_ready_o = !full_o;
  assign out_valid_o = !empty_o;
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || flush_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // A push that slips past a full FIFO would lift the count past DEPTH and drop full.
  a_fifo_no_over: assert property (@(posedge clk_i)
    disable iff (!rst_b_i) full_o && !out_ready_i && !flush_i |=> full_o)
    else $error("fifo overfilled");
endmodule : ecp_fifo

// ==== core/ecp_parallel_port.sv ====
// ECP parallel port core: host registers at two bases and the pin handshake.
// Assumes the host I/O strobes are synchronous one-cycle pulses on CLK_I.
`timescale 1ns/1ps
module ecp_parallel_port
  import ecp_pkg::*;
(
  input wire logic CLK_I, // 100 MHz clock.
  input wire logic RST_B_I, // Synchronous reset, active low.
  input wire logic IO_WR_I, // Host write pulse.
  input wire logic IO_RD_I, // Host read pulse.
  input wire logic IO_BASE2_I, // Access selects base 2 when high.
  input wire logic [1:0] IO_ADDR_I, // Offset within the base.
  input wire logic [7:0] IO_WDATA_I, // Write data.
  output logic [7:0] IO_RDATA_O, // Read data, registered.
  output logic IO_RVALID_O, // Read data valid pulse.
  output logic IRQ_O, // Peripheral event interrupt pulse.
  input wire logic [7:0] PORT_BUS_I, // Port bus level.
  output logic [7:0] PORT_BUS_O, // Port bus drive value.
  output logic PORT_BUS_OE_O, // Port bus driven when high.
  output logic HOST_WRITE_PULSE_N_O, // Host strobe, active low.
  output logic HOST_REPLY_OUT_N_O, // Host reply, active low.
  output logic TURNAROUND_ASK_N_O, // Turnaround request, active low.
  output logic LINK_ACTIVE_OUT_N_O, // Active indicator, active low.
  input wire logic PERIPH_PACING_IN_N_I, // Peripheral clock.
  input wire logic PERIPH_FLOW_REPLY_I, // Peripheral flow reply.
  input wire logic PAPER_FAULT_IN_I, // Paper error / turnaround reply.
  input wire logic ONLINE_IN_I, // Online indication.
  input wire logic PERIPH_ERROR_IN_N_I // Fault / reverse wish.
);
  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  pins_in_t pin_s1_r;
  pins_in_t pin_r;
  logic [7:0] bus_s1_r;
  logic [7:0] bus_r;
  logic rev_clk_d_r;
  logic fault_d_r;

  always_ff @(posedge CLK_I) begin
    pin_s1_r <= {PERIPH_FLOW_REPLY_I, PERIPH_PACING_IN_N_I, PAPER_FAULT_IN_I,
                 ONLINE_IN_I, PERIPH_ERROR_IN_N_I};
    pin_r <= pin_s1_r;
    bus_s1_r <= PORT_BUS_I;
    bus_r <= bus_s1_r;
    rev_clk_d_r <= pin_r.rev_clk;
    fault_d_r <= pin_r.fault_n;
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  port_mode_t mode_r;
  logic [5:0] ctrl_r;
  logic [7:0] data_r;
  logic [4:0] ext_low_r;
  logic [7:0] last_r;
  logic dir;
  logic wr1;
  logic wr2;
  logic rd2;
  logic ecp_fwd;

  assign wr1 = IO_WR_I && !IO_BASE2_I;
  assign wr2 = IO_WR_I && IO_BASE2_I;
  assign rd2 = IO_RD_I && IO_BASE2_I;
  // Standard mode forces forward; parallel FIFO mode is forward only.
  assign dir = ctrl_r[5] && (mode_r != MODE_STD) && (mode_r != MODE_PFIFO);
  assign ecp_fwd = (mode_r == MODE_ECP) && !dir;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      mode_r <= port_mode_t'(EXT_MODE_RESET);
      ext_low_r <= '0;
    end else if (wr2 && IO_ADDR_I == OFF_EXT_CTRL) begin
      mode_r <= port_mode_t'(IO_WDATA_I[7:5]);
      ext_low_r <= {IO_WDATA_I[4:2], 2'h0};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ctrl_r <= CONTROL_RESET;
    end else if (wr1 && IO_ADDR_I == OFF_CONTROL) begin
      ctrl_r <= IO_WDATA_I[5:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      data_r <= DATA_RESET;
    end else if (wr1 && IO_ADDR_I == OFF_DATA &&
                 (mode_r == MODE_STD || mode_r == MODE_PS2)) begin
      data_r <= IO_WDATA_I;
    end
  end

  // -------------------------------------------------------------------------
  // FIFO and its feeds
  // -------------------------------------------------------------------------
  fifo_word_t fin;
  fifo_word_t fout;
  logic fin_v;
  logic fin_rdy;
  logic fout_v;
  logic fout_rdy;
  logic full;
  logic empty;
  logic host_push;
  logic rev_push;
  logic link_pop;
  logic host_pop;

  // Host writes: address port in ECP forward, FIFO port in PFIFO/ECP forward/test.
  always_comb begin
    host_push = 1'b0;
    fin.tag = 1'b0;
    fin.byte_v = IO_WDATA_I;
    if (wr1 && IO_ADDR_I == OFF_DATA && ecp_fwd) begin
      host_push = 1'b1;
      fin.tag = 1'b1;
    end else if (wr2 && IO_ADDR_I == OFF_FIFO) begin
      host_push = (mode_r == MODE_PFIFO) || ecp_fwd || (mode_r == MODE_TEST);
    end
    if (rev_push) begin
      fin.tag = pin_r.flow_reply;
      fin.byte_v = bus_r;
    end
  end
  assign fin_v = host_push || rev_push;
  assign host_pop = rd2 && IO_ADDR_I == OFF_FIFO &&
                    (mode_r == MODE_TEST || (mode_r == MODE_ECP && dir));
  assign fout_rdy = link_pop || host_pop;

  ecp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .flush_i(mode_r == MODE_STD),
    .in_data_i(fin),
    .in_valid_i(fin_v),
    .in_ready_o(fin_rdy),
    .out_data_o(fout),
    .out_valid_o(fout_v),
    .out_ready_i(fout_rdy),
    .full_o(full),
    .empty_o(empty)
  );

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      last_r <= '0;
    end else if (host_pop && fout_v) begin
      last_r <= fout.byte_v;
    end
  end

  // -------------------------------------------------------------------------
  // Link handshake
  // -------------------------------------------------------------------------
  link_state_t st_r;
  logic [7:0] cnt_r;
  logic [7:0] out_r;
  logic out_tag_r;
  logic auto_fwd;

  assign auto_fwd = (mode_r == MODE_PFIFO) || ecp_fwd;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      st_r <= LK_IDLE;
      cnt_r <= '0;
      out_r <= '0;
      out_tag_r <= 1'b0;
    end else begin
      case (st_r)
        LK_IDLE: begin
          cnt_r <= '0;
          if (auto_fwd && fout_v && !pin_r.flow_reply) begin
            out_r <= fout.byte_v;
            out_tag_r <= fout.tag;
            st_r <= LK_SETUP;
          end else if (mode_r == MODE_ECP && dir && fin_rdy) begin
            st_r <= LK_REV;
          end
        end
        LK_SETUP: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == PULSE_CYC) begin
            cnt_r <= '0;
            st_r <= LK_STROBE;
          end
        end
        LK_STROBE: begin
          cnt_r <= cnt_r + 8'h01;
          // ECP waits for the flow reply; parallel FIFO mode uses a timed pulse.
          if ((ecp_fwd && pin_r.flow_reply) ||
              (!ecp_fwd && cnt_r == PULSE_CYC)) begin
            st_r <= LK_WAIT_REL;
          end
        end
        LK_WAIT_REL: begin
          if (!pin_r.flow_reply) begin
            st_r <= LK_IDLE;
          end
        end
        LK_REV: begin
          if (!(mode_r == MODE_ECP && dir)) begin
            st_r <= LK_IDLE;
          end else if (!pin_r.rev_clk && rev_clk_d_r) begin
            st_r <= LK_IDLE;
          end
        end
        default: begin
          st_r <= LK_IDLE;
        end
      endcase
    end
  end

  assign link_pop = (st_r == LK_IDLE) && auto_fwd && fout_v &&
                    !pin_r.flow_reply;
  assign rev_push = (st_r == LK_REV) && (mode_r == MODE_ECP) && dir &&
                    !pin_r.rev_clk && rev_clk_d_r && fin_rdy;

  always_comb begin
    HOST_WRITE_PULSE_N_O = !ctrl_r[0];
    HOST_REPLY_OUT_N_O = !ctrl_r[1];
    TURNAROUND_ASK_N_O = ctrl_r[2];
    LINK_ACTIVE_OUT_N_O = !ctrl_r[3];
    if (auto_fwd) begin
      HOST_WRITE_PULSE_N_O = (st_r != LK_STROBE);
      HOST_REPLY_OUT_N_O = !(ecp_fwd && out_tag_r);
    end
    if (mode_r == MODE_ECP) begin
      LINK_ACTIVE_OUT_N_O = 1'b1;
      if (dir) begin
        HOST_REPLY_OUT_N_O = (st_r != LK_REV);
      end
    end
  end

  // Bus is released in reverse so the peripheral may drive it.
  assign PORT_BUS_OE_O = !dir;
  always_comb begin
    PORT_BUS_O = data_r;
    if (auto_fwd) begin
      PORT_BUS_O = out_r;
    end else if (mode_r == MODE_TEST) begin
      PORT_BUS_O = fout.byte_v;
    end
  end

  // -------------------------------------------------------------------------
  // Events
  // -------------------------------------------------------------------------
  logic irq_r;
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (ctrl_r[4] && pin_r.rev_clk && !rev_clk_d_r) ||
               (ecp_fwd && !pin_r.fault_n && fault_d_r);
    end
  end
  assign IRQ_O = irq_r;

  // -------------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------------
  logic [7:0] rd_nxt;
  always_comb begin
    rd_nxt = 8'h00;
    if (!IO_BASE2_I) begin
      case (IO_ADDR_I)
        OFF_DATA: rd_nxt = dir ? bus_r : data_r;
        OFF_STATUS: rd_nxt = {!pin_r.flow_reply, pin_r.rev_clk, pin_r.paper,
                              pin_r.online, pin_r.fault_n, 3'h7};
        OFF_CONTROL: rd_nxt = {2'h3, ctrl_r};
        default: rd_nxt = 8'h00;
      endcase
    end else begin
      case (IO_ADDR_I)
        OFF_FIFO: begin
          if (mode_r == MODE_CFG) begin
            rd_nxt = CFG_A_VALUE;
          end else if (host_pop) begin
            rd_nxt = fout_v ? fout.byte_v : last_r;
          end
        end
        OFF_CFG_B: rd_nxt = (mode_r == MODE_CFG) ? CFG_B_VALUE : 8'h00;
        OFF_EXT_CTRL: rd_nxt = {mode_r, ext_low_r[4:2], full, empty};
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      IO_RDATA_O <= '0;
      IO_RVALID_O <= 1'b0;
    end else begin
      IO_RVALID_O <= IO_RD_I;
      if (IO_RD_I) begin
        IO_RDATA_O <= rd_nxt;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  sequence s_strobe_start;
    st_r == LK_SETUP && cnt_r == PULSE_CYC;
  endsequence

  a_strobe_active: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) s_strobe_start |=> !HOST_WRITE_PULSE_N_O)
    else $error("strobe not asserted after setup");
  a_active_high: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) mode_r == MODE_ECP |-> LINK_ACTIVE_OUT_N_O)
    else $error("active indicator low in ECP mode");
  a_status_ones: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) IO_RD_I && !IO_BASE2_I && IO_ADDR_I == OFF_STATUS
    |=> IO_RDATA_O[2:0] == 3'h7 && IO_RDATA_O[7] == !$past(pin_r.flow_reply))
    else $error("status read wrong");
  a_control_top: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) IO_RD_I && !IO_BASE2_I && IO_ADDR_I == OFF_CONTROL
    |=> IO_RDATA_O[7:6] == 2'h3) else $error("control top bits low");
  a_std_forward: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) mode_r == MODE_STD |-> PORT_BUS_OE_O)
    else $error("std not driving");
  a_irq_edge: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) ctrl_r[4] && $rose(pin_r.rev_clk) |=> IRQ_O)
    else $error("no interrupt on peripheral clock edge");
  a_turn_pin: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) TURNAROUND_ASK_N_O == ctrl_r[2])
    else $error("turnaround drive wrong");
  a_cfg_a_val: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) rd2 && IO_ADDR_I == OFF_FIFO && mode_r == MODE_CFG
    |=> IO_RDATA_O == CFG_A_VALUE) else $error("cfg A wrong");
  a_addr_tag: assert property (@(posedge CLK_I)
    disable iff (!RST_B_I) wr1 && IO_ADDR_I == OFF_DATA && ecp_fwd
    |-> fin_v && fin.tag) else $error("address byte not tagged");
endmodule : ecp_parallel_port

// ==== bench/ecp_periph_model.sv ====
// Behavioural peripheral on the far side of the ECP parallel port.
// Assumes the bench resolves the shared bus and feeds the level back in.
`timescale 1ns/1ps
module ecp_periph_model
  import ecp_pkg::*;
(
  input wire logic clk_i, // Clock.
  input wire logic manual_i, // Bench owns the pins when high.
  input wire pins_in_t man_i, // Pin values in manual use.
  input wire logic [7:0] rev_n_i, // Bytes to offer in reverse.
  input wire logic [7:0] bus_i, // Resolved bus level.
  input wire logic strobe_n_i, // Host strobe.
  input wire logic reply_n_i, // Host reply.
  input wire logic ask_n_i, // Turnaround request.
  input wire logic active_n_i, // Active indicator.
  output pins_in_t pins_o, // Pin levels toward the port.
  output logic [7:0] bus_o, // Bus drive value.
  output logic bus_oe_o // Bus driven when high.
);
  pins_in_t m;
  logic [8:0] got_w [0:31];
  int got_cnt;
  int sent;

  assign pins_o = manual_i ? man_i : m;

  initial begin
    m = '{flow_reply: 1'b0, rev_clk: 1'b1, paper: 1'b1, online: 1'b1,
          fault_n: 1'b1};
    bus_o = 8'h00;
    bus_oe_o = 1'b0;
    got_cnt = 0;
    sent = 0;
    forever begin
      @(posedge clk_i);
      if (strobe_n_i === 1'b0) begin
        got_w[got_cnt] = {~reply_n_i, bus_i};
        got_cnt++;
        repeat (3) @(posedge clk_i);
        m.flow_reply <= 1'b1;
        while (strobe_n_i !== 1'b1) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        m.flow_reply <= 1'b0;
      end else if (ask_n_i === 1'b0 && active_n_i === 1'b1) begin
        m.paper <= 1'b0;
        if (reply_n_i === 1'b0 && sent < int'(rev_n_i)) begin
          bus_oe_o <= 1'b1;
          bus_o <= 8'h50 + 8'(sent);
          m.flow_reply <= 1'b1;
          repeat (4) @(posedge clk_i);
          m.rev_clk <= 1'b0;
          repeat (8) @(posedge clk_i);
          m.rev_clk <= 1'b1;
          sent++;
          repeat (8) @(posedge clk_i);
        end
      end else begin
        // A released bus must not keep showing the last byte.
        m.paper <= 1'b1;
        bus_oe_o <= 1'b0;
        m.flow_reply <= 1'b0;
      end
    end
  end
endmodule : ecp_periph_model

// ==== bench/ecp_parallel_port_tb.sv ====
// Self-checking bench for the ECP parallel port core.
// Assumes the peripheral model and a resolved bus between the two.
`timescale 1ns/1ps
module ecp_parallel_port_tb
  import ecp_pkg::*;
;
  logic clk, rst_b, wr, rd, base2, irq, rvalid, manual;
  logic bus_oe, p_oe, stb_n, rep_n, ask_n, act_n;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, bus_o, bus_w, last_r, p_bus, rev_n;
  pins_in_t pins, man;
  int err_count, checks;

  // Undriven bus shows the inverse of the last driven byte.
  assign bus_w = bus_oe ? bus_o : (p_oe ? p_bus : ~last_r);
  always @(posedge clk) begin
    if (bus_oe || p_oe) begin
      last_r <= bus_w;
    end
  end

  ecp_parallel_port dut_u (.CLK_I(clk), .RST_B_I(rst_b), .IO_WR_I(wr),
    .IO_RD_I(rd), .IO_BASE2_I(base2), .IO_ADDR_I(addr),
    .IO_WDATA_I(wdata), .IO_RDATA_O(rdata), .IO_RVALID_O(rvalid),
    .IRQ_O(irq), .PORT_BUS_I(bus_w), .PORT_BUS_O(bus_o),
    .PORT_BUS_OE_O(bus_oe), .HOST_WRITE_PULSE_N_O(stb_n),
    .HOST_REPLY_OUT_N_O(rep_n), .TURNAROUND_ASK_N_O(ask_n),
    .LINK_ACTIVE_OUT_N_O(act_n), .PERIPH_PACING_IN_N_I(pins.rev_clk),
    .PERIPH_FLOW_REPLY_I(pins.flow_reply), .PAPER_FAULT_IN_I(pins.paper),
    .ONLINE_IN_I(pins.online), .PERIPH_ERROR_IN_N_I(pins.fault_n));

  ecp_periph_model periph_u (.clk_i(clk), .manual_i(manual), .man_i(man),
    .rev_n_i(rev_n), .bus_i(bus_w), .strobe_n_i(stb_n), .reply_n_i(rep_n),
    .ask_n_i(ask_n), .active_n_i(act_n), .pins_o(pins), .bus_o(p_bus),
    .bus_oe_o(p_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------
  // Helpers
  // ------------
  task automatic finish_test;
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic b, input logic [1:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    base2 <= b;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic b,
                        input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    base2 <= b;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk(nm, e, rdata);
  endtask : rd_chk

  // ------------
  // Scenarios
  // ------------
  task automatic t_reset;
    chk("pins", 8'h0b, {4'h0, act_n, ask_n, rep_n, stb_n});
    rd_chk("ctrl", 1'b0, 2'h2, 8'hc0);
    rd_chk("data", 1'b0, 2'h0, 8'h00);
    rd_chk("ecr", 1'b1, 2'h2, 8'h01);
  endtask : t_reset

  task automatic t_data;
    wr_reg(1'b0, 2'h0, 8'ha5);
    rd_chk("data", 1'b0, 2'h0, 8'ha5);
    chk("bus", 8'ha5, bus_o);
    wr_reg(1'b0, 2'h2, 8'h24);
    cyc(2);
    chk("oe", 8'h01, {7'h00, bus_oe});
    wr_reg(1'b1, 2'h2, 8'h20);
    wr_reg(1'b0, 2'h2, 8'h24);
    cyc(2);
    chk("oe", 8'h00, {7'h00, bus_oe});
    wr_reg(1'b0, 2'h2, 8'h04);
    wr_reg(1'b1, 2'h2, 8'h00);
  endtask : t_data

  task automatic t_ctrl;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 8'h01 << i;
      wr_reg(1'b0, 2'h2, v);
      cyc(2);
      chk("pins", {4'h0, ~v[3], v[2], ~v[1], ~v[0]},
          {4'h0, act_n, ask_n, rep_n, stb_n});
    end
    wr_reg(1'b0, 2'h2, 8'h0f);
    rd_chk("ctrl", 1'b0, 2'h2, 8'hcf);
    wr_reg(1'b0, 2'h2, 8'h04);
  endtask : t_ctrl

  task automatic t_status;
    manual <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      man <= pins_in_t'(i == 0 ? 5'h15 : 5'h0a);
      cyc(4);
      rd_chk("status", 1'b0, 2'h1, {~man.flow_reply, man.rev_clk,
             man.paper, man.online, man.fault_n, 3'h7});
    end
  endtask : t_status

  task automatic irq_seen(input logic [7:0] e);
    logic s;
    s = 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (irq === 1'b1) s = 1'b1;
    end
    chk("irq", e, {7'h00, s});
  endtask : irq_seen

  task automatic t_irq;
    @(posedge clk);
    man <= pins_in_t'(5'h03);
    wr_reg(1'b0, 2'h2, 8'h14);
    cyc(4);
    @(posedge clk);
    man.rev_clk <= 1'b1;
    irq_seen(8'h01);
    @(posedge clk);
    man.rev_clk <= 1'b0;
    wr_reg(1'b0, 2'h2, 8'h04);
    cyc(4);
    @(posedge clk);
    man.rev_clk <= 1'b1;
    irq_seen(8'h00);
    @(posedge clk);
    manual <= 1'b0;
  endtask : t_irq

  task automatic t_cfg;
    wr_reg(1'b1, 2'h2, 8'h20);
    wr_reg(1'b1, 2'h2, 8'he0);
    wr_reg(1'b1, 2'h0, 8'h5a);
    wr_reg(1'b1, 2'h1, 8'hff);
    rd_chk("cfga", 1'b1, 2'h0, CFG_A_VALUE);
    rd_chk("cfgb", 1'b1, 2'h1, 8'h00);
    wr_reg(1'b1, 2'h2, 8'h20);
  endtask : t_cfg

  task automatic t_test_fifo_port;
    wr_reg(1'b1, 2'h2, 8'hc0);
    for (int i = 0; i < 17; i++) begin
      wr_reg(1'b1, 2'h0, 8'h10 + 8'(i));
    end
    rd_chk("ecr", 1'b1, 2'h2, 8'hc2);
    chk("bus", 8'h10, bus_o);
    chk("stb", 8'h01, {7'h00, stb_n});
    for (int i = 0; i < 16; i++) begin
      rd_chk("test_fifo_port", 1'b1, 2'h0, 8'h10 + 8'(i));
    end
    rd_chk("test_fifo_port", 1'b1, 2'h0, 8'h1f);
    rd_chk("ecr", 1'b1, 2'h2, 8'hc1);
    wr_reg(1'b1, 2'h2, 8'h20);
  endtask : t_test_fifo_port

  task automatic t_fwd;
    int n0;
    logic [8:0] g;
    wr_reg(1'b1, 2'h2, 8'h40);
    n0 = periph_u.got_cnt;
    wr_reg(1'b1, 2'h0, 8'hc3);
    cyc(150);
    g = periph_u.got_w[n0];
    chk("pfifo", 8'hc3, g[7:0]);
    chk("pcnt", 8'h01, 8'(periph_u.got_cnt - n0));
    chk("pstb", 8'h01, {7'h00, stb_n});
    wr_reg(1'b1, 2'h2, 8'h60);
    n0 = periph_u.got_cnt;
    wr_reg(1'b1, 2'h0, 8'h3c);
    wr_reg(1'b0, 2'h0, 8'h81);
    for (int k = 0; k < 2000 && periph_u.got_cnt < n0 + 2; k++) begin
      @(posedge clk);
    end
    g = periph_u.got_w[n0];
    chk("fwd0", 8'h3c, g[7:0]);
    chk("tag0", 8'h00, {7'h00, g[8]});
    g = periph_u.got_w[n0 + 1];
    chk("fwd1", 8'h81, g[7:0]);
    chk("tag1", 8'h01, {7'h00, g[8]});
    chk("active", 8'h01, {7'h00, act_n});
    cyc(10);
    rd_chk("ecr", 1'b1, 2'h2, 8'h61);
    @(posedge clk);
    man <= pins_in_t'(5'h0f);
    manual <= 1'b1;
    cyc(4);
    @(posedge clk);
    man.fault_n <= 1'b0;
    irq_seen(8'h01);
    @(posedge clk);
    manual <= 1'b0;
    wr_reg(1'b1, 2'h2, 8'h20);
  endtask : t_fwd

  task automatic t_rev;
    wr_reg(1'b0, 2'h2, 8'h20);
    rev_n <= 8'h03;
    wr_reg(1'b1, 2'h2, 8'h60);
    for (int k = 0; k < 2000 && periph_u.sent < 3; k++) begin
      @(posedge clk);
    end
    cyc(6);
    chk("oe", 8'h00, {7'h00, bus_oe});
    chk("ack", 8'h00, {7'h00, pins.paper});
    for (int i = 0; i < 3; i++) begin
      rd_chk("rev", 1'b1, 2'h0, 8'h50 + 8'(i));
    end
    wr_reg(1'b1, 2'h2, 8'h20);
    wr_reg(1'b0, 2'h2, 8'h04);
  endtask : t_rev

  task automatic t_rst2;
    wr_reg(1'b0, 2'h0, 8'h5a);
    wr_reg(1'b0, 2'h2, 8'h2b);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    cyc(3);
    t_reset;
  endtask : t_rst2

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test;
  end

  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    base2 = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    manual = 1'b0;
    man = pins_in_t'(5'h1f);
    rev_n = 8'h00;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    cyc(3);
    t_reset;
    t_data;
    t_ctrl;
    t_status;
    t_irq;
    t_cfg;
    t_test_fifo_port;
    t_fwd;
    t_rev;
    t_rst2;
    finish_test;
  end
endmodule : ecp_parallel_port_tb
